// ==== include/inhibit_sync_regs.vh ====
// Register offsets, field positions, reset values and timing for the inhibit and sync-on pins.
`ifndef INHIBIT_SYNC_REGS_VH
`define INHIBIT_SYNC_REGS_VH

// Byte offsets on the AHB-Lite bus.
`define REG_PIN_CTRL      8'h00
`define REG_COMMAND       8'h04
`define REG_STATE         8'h08
`define REG_IRQ_STATUS    8'h0c
`define REG_IRQ_MASK      8'h10
`define REG_PWM_INHIBIT   8'h14
`define REG_PWM_SYNC      8'h18

// Pin control fields; the sync pin uses the same layout shifted by CTRL_SYNC_BASE.
`define CTRL_INVERT       0
`define CTRL_FUNC         1
`define CTRL_STATIC_LO    2
`define CTRL_STATIC_HI    3
`define CTRL_LATCH        4
`define CTRL_SYNC_BASE    8
`define CTRL_WIDTH        13
`define CTRL_RESET        13'h0000

// Static output settings.
`define STATIC_ZERO       2'h0
`define STATIC_ONE        2'h1

// Command bits, write-only.
`define CMD_TURN_ON       0
`define CMD_TURN_OFF      1
`define CMD_CLEAR_TRIP    2

// State bits, read-only.
`define ST_OUTPUT_ON      0
`define ST_OUTPUT_ACTIVE  1
`define ST_LEVEL_INHIBIT  2
`define ST_TRIP_PROTECT   3
`define ST_SYNC_EMITTING  4
`define ST_INHIBIT_PIN    5
`define ST_SYNC_PIN       6

// Interrupt status and mask bits.
`define IRQ_TRIP          0
`define IRQ_SYNC_TURN_ON  1
`define IRQ_LEVEL_INHIBIT 2
`define IRQ_WIDTH         3
`define IRQ_RESET         3'h0

// PWM register: period in cycles in the low half, cycles at value 1 in the high half.
`define PWM_RESET         32'h0000_0000

// Pulse timing.
`define PULSE_LOW_NS      30000
`define CLK_FREQ_MHZ      250

`endif

// ==== logic/inhibit_sync_io_control.v ====
// Inhibit and sync-on control pin logic with an AHB-Lite register slave.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "inhibit_sync_regs.vh"

// Notes on behaviour
// - Each pin has an invert option reversing sense of input and output signals.
// - Static output setting drives 1, 0 or PWM with separate frequency and duty.
// - Uninverted, value 1 drives pin low and 0 high; inverted, swapped.
// - Level mode: an idle high inhibit pin leaves the output unaffected.
// - Level mode: active inhibit level zeroes actual output; on/off state stays on.
// - Level mode: releasing the inhibit level restores the output by itself.
// - While level inhibit holds output at zero, a distinct status is asserted.
// - Latch mode: a valid inhibit pulse while on switches the state off.
// - After a latch trip only a manual turn-on command re-enables output; here it is ignored until CMD_CLEAR_TRIP clears the trip flag.
// - A latch trip sets a protection flag kept until explicitly cleared.
// - Latch mode: an unconnected inhibit pin has no effect.
// - Sync-on mode: every off to on change emits a pulse on the sync pin.
// - Sync-on mode: a received pulse while on leaves the state unchanged.
// - Sync-on mode: a received pulse while off switches the state on.
// - The emitted sync pulse holds its active phase at least 30us.
module inhibit_sync_io_control #(
  parameter MIN_LOW_CYCLES = (`PULSE_LOW_NS * `CLK_FREQ_MHZ + 999) / 1000
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        inhibitIn,
  output reg         inhibitOut,
  output reg         inhibitOe,
  input  wire        syncIn,
  output reg         syncOut,
  output reg         syncOe,
  output reg         outputOn,
  output reg         outputActive,
  output reg         levelInhibitStatus,
  output reg         tripProtectionStatus,
  output reg         irq
);

  localparam [15:0] MIN_LOW = MIN_LOW_CYCLES[15:0];

  // Software-visible state.
  reg  [`CTRL_WIDTH-1:0] pinCtrl;
  reg  [`IRQ_WIDTH-1:0]  irqStatus;
  reg  [`IRQ_WIDTH-1:0]  irqMask;
  reg  [31:0]            pwmInhibit;
  reg  [31:0]            pwmSync;

  // Bus data phase.
  reg         dataValid;
  reg         dataWrite;
  reg  [7:0]  dataAddr;
  reg         readPending;

  // Sync pulse emitter.
  reg  [15:0] emitCount;
  wire        emitting = (emitCount != 16'h0000);

  // Per-pin view: index 0 is the inhibit pin, index 1 the sync pin.
  wire [1:0]  pinIn   = {syncIn, inhibitIn};
  wire [1:0]  invert  = {pinCtrl[`CTRL_SYNC_BASE + `CTRL_INVERT], pinCtrl[`CTRL_INVERT]};
  wire [1:0]  pinActive;
  wire [1:0]  pulseSeen;
  wire [1:0]  pwmBit;
  wire [1:0]  pinLevel;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : pinLogic
      reg  [1:0]  syncFf;
      reg  [15:0] lowCount;
      reg  [15:0] pwmCount;
      wire [31:0] pwmCfg = (i == 0) ? pwmInhibit : pwmSync;

      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          syncFf <= 2'h3;
        end else begin
          syncFf <= {syncFf[0], pinIn[i]};
        end
      end

      assign pinLevel[i]  = syncFf[1];
      // Uninverted pins are active low; invert makes the high level active.
      assign pinActive[i] = invert[i] ? syncFf[1] : ~syncFf[1];

      // Width filter: a pulse counts once its active phase reaches the minimum.
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          lowCount <= 16'h0000;
        end else if (!pinActive[i]) begin
          lowCount <= 16'h0000;
        end else if (lowCount != MIN_LOW) begin
          lowCount <= lowCount + 16'h0001;
        end
      end

      assign pulseSeen[i] = pinActive[i] && (lowCount == MIN_LOW - 16'h0001);

      // PWM counter wraps at the programmed period; a zero period holds the count at 0.
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          pwmCount <= 16'h0000;
        end else if (pwmCount + 16'h0001 >= pwmCfg[15:0]) begin
          pwmCount <= 16'h0000;
        end else begin
          pwmCount <= pwmCount + 16'h0001;
        end
      end

      assign pwmBit[i] = (pwmCount < pwmCfg[31:16]);
    end
  endgenerate

  // Decoded configuration.
  wire inhStatic  = pinCtrl[`CTRL_FUNC];
  wire inhLatch   = pinCtrl[`CTRL_LATCH];
  wire syncStatic = pinCtrl[`CTRL_SYNC_BASE + `CTRL_FUNC];
  wire [1:0] inhSel  = pinCtrl[`CTRL_STATIC_HI:`CTRL_STATIC_LO];
  wire [1:0] syncSel = pinCtrl[`CTRL_SYNC_BASE + `CTRL_STATIC_HI:
                               `CTRL_SYNC_BASE + `CTRL_STATIC_LO];

  // Static output values before the pin mapping.
  wire inhValue  = (inhSel == `STATIC_ZERO) ? 1'b0 :
                   (inhSel == `STATIC_ONE)  ? 1'b1 : pwmBit[0];
  wire syncValue = (syncSel == `STATIC_ZERO) ? 1'b0 :
                   (syncSel == `STATIC_ONE)  ? 1'b1 : pwmBit[1];

  // Bus decode.
  wire addrTaken = hsel && hready && htrans[1];
  wire wrActive  = dataValid && dataWrite;
  wire [31:0] wdata = hwdata;
  wire cmdWrite  = wrActive && (dataAddr == `REG_COMMAND);
  wire turnOnCmd  = cmdWrite && wdata[`CMD_TURN_ON];
  wire turnOffCmd = cmdWrite && wdata[`CMD_TURN_OFF];
  wire clearTrip  = cmdWrite && wdata[`CMD_CLEAR_TRIP];

  // Events from the pins.
  wire inhibitPulse = !inhStatic && inhLatch && pulseSeen[0];
  wire tripEvent    = inhibitPulse && outputOn;
  // Our own emitted pulse is seen on the wire, so reception waits until it ends.
  wire syncRx       = !syncStatic && !emitting && pulseSeen[1];
  wire syncTurnOn   = syncRx && !outputOn && !tripProtectionStatus;
  wire levelHold    = !inhStatic && !inhLatch && pinActive[0];

  // Next values for the on/off state and its companions.
  reg next_outputOn;
  reg next_trip;
  reg next_levelInhibit;
  reg next_outputActive;
  reg [`IRQ_WIDTH-1:0] irqEvents;
  reg [`IRQ_WIDTH-1:0] next_irqStatus;

  always @* begin
    next_outputOn = outputOn;
    if (tripEvent || turnOffCmd) begin
      next_outputOn = 1'b0;
    end else if (turnOnCmd && !tripProtectionStatus) begin
      next_outputOn = 1'b1;
    end else if (syncTurnOn) begin
      next_outputOn = 1'b1;
    end

    // Setting wins over clearing in the same cycle.
    next_trip = tripProtectionStatus;
    if (clearTrip) begin
      next_trip = 1'b0;
    end
    if (tripEvent) begin
      next_trip = 1'b1;
    end

    // Level inhibit follows the pin; the on/off state itself is untouched.
    next_levelInhibit = levelHold && next_outputOn;
    next_outputActive = next_outputOn && !next_levelInhibit;

    irqEvents = {`IRQ_WIDTH{1'b0}};
    irqEvents[`IRQ_TRIP]          = tripEvent;
    irqEvents[`IRQ_SYNC_TURN_ON]  = syncTurnOn;
    irqEvents[`IRQ_LEVEL_INHIBIT] = next_levelInhibit && !levelInhibitStatus;

    next_irqStatus = irqStatus;
    if (wrActive && (dataAddr == `REG_IRQ_STATUS)) begin
      next_irqStatus = irqStatus & ~wdata[`IRQ_WIDTH-1:0];
    end
    next_irqStatus = next_irqStatus | irqEvents;
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      outputOn             <= 1'b0;
      tripProtectionStatus <= 1'b0;
      levelInhibitStatus   <= 1'b0;
      outputActive         <= 1'b0;
      irqStatus            <= `IRQ_RESET;
      irq                  <= 1'b0;
    end else begin
      outputOn             <= next_outputOn;
      tripProtectionStatus <= next_trip;
      levelInhibitStatus   <= next_levelInhibit;
      outputActive         <= next_outputActive;
      irqStatus            <= next_irqStatus;
      irq                  <= |(next_irqStatus & irqMask);
    end
  end

  // Sync pulse emitter, started on every off to on change in sync-on mode.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      emitCount <= 16'h0000;
    end else if (!syncStatic && next_outputOn && !outputOn) begin
      emitCount <= MIN_LOW;
    end else if (emitting) begin
      emitCount <= emitCount - 16'h0001;
    end
  end

  // Pin drivers.
  reg next_inhibitOut;
  reg next_inhibitOe;
  reg next_syncOut;
  reg next_syncOe;

  always @* begin
    next_inhibitOut = 1'b0;
    next_inhibitOe  = 1'b0;
    if (inhStatic) begin
      next_inhibitOut = invert[0] ? inhValue : ~inhValue;
      next_inhibitOe  = 1'b1;
    end
    if (syncStatic) begin
      next_syncOut = invert[1] ? syncValue : ~syncValue;
      next_syncOe  = 1'b1;
    end else begin
      // The pin is released between pulses so a partner can drive it.
      next_syncOut = invert[1];
      next_syncOe  = emitting && !(!syncStatic && next_outputOn && !outputOn) ?
                     (emitCount != 16'h0001) : (next_outputOn && !outputOn);
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      inhibitOut <= 1'b0;
      inhibitOe  <= 1'b0;
      syncOut    <= 1'b0;
      syncOe     <= 1'b0;
    end else begin
      inhibitOut <= next_inhibitOut;
      inhibitOe  <= next_inhibitOe;
      syncOut    <= next_syncOut;
      syncOe     <= next_syncOe;
    end
  end

  // Register read mux, evaluated in the read data phase so earlier writes are seen.
  reg [31:0] readData;

  always @* begin
    readData = 32'h0000_0000;
    case (dataAddr)
      `REG_PIN_CTRL: begin
        readData[`CTRL_WIDTH-1:0] = pinCtrl;
      end
      `REG_STATE: begin
        readData[`ST_OUTPUT_ON]     = outputOn;
        readData[`ST_OUTPUT_ACTIVE] = outputActive;
        readData[`ST_LEVEL_INHIBIT] = levelInhibitStatus;
        readData[`ST_TRIP_PROTECT]  = tripProtectionStatus;
        readData[`ST_SYNC_EMITTING] = emitting;
        readData[`ST_INHIBIT_PIN]   = pinLevel[0];
        readData[`ST_SYNC_PIN]      = pinLevel[1];
      end
      `REG_IRQ_STATUS: begin
        readData[`IRQ_WIDTH-1:0] = irqStatus;
      end
      `REG_IRQ_MASK: begin
        readData[`IRQ_WIDTH-1:0] = irqMask;
      end
      `REG_PWM_INHIBIT: begin
        readData = pwmInhibit;
      end
      `REG_PWM_SYNC: begin
        readData = pwmSync;
      end
      default: begin
        readData = 32'h0000_0000;
      end
    endcase
  end

  // AHB-Lite slave: writes take no wait state, reads take one.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataValid   <= 1'b0;
      dataWrite   <= 1'b0;
      dataAddr    <= 8'h00;
      readPending <= 1'b0;
      hreadyout   <= 1'b1;
      hrdata      <= 32'h0000_0000;
      hresp       <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (readPending) begin
        hrdata      <= readData;
        hreadyout   <= 1'b1;
        readPending <= 1'b0;
        dataValid   <= 1'b0;
      end else if (addrTaken) begin
        dataValid   <= 1'b1;
        dataWrite   <= hwrite;
        dataAddr    <= {haddr[7:2], 2'b00};
        readPending <= !hwrite;
        hreadyout   <= hwrite;
      end else begin
        dataValid <= 1'b0;
      end
    end
  end

  // Configuration registers written in the data phase.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pinCtrl    <= `CTRL_RESET;
      irqMask    <= `IRQ_RESET;
      pwmInhibit <= `PWM_RESET;
      pwmSync    <= `PWM_RESET;
    end else if (wrActive) begin
      case (dataAddr)
        `REG_PIN_CTRL: begin
          pinCtrl <= wdata[`CTRL_WIDTH-1:0];
        end
        `REG_IRQ_MASK: begin
          irqMask <= wdata[`IRQ_WIDTH-1:0];
        end
        `REG_PWM_INHIBIT: begin
          pwmInhibit <= wdata;
        end
        `REG_PWM_SYNC: begin
          pwmSync <= wdata;
        end
        default: begin
          pinCtrl <= pinCtrl;
        end
      endcase
    end
  end

endmodule // inhibit_sync_io_control

// ==== verif/pin_partner.sv ====
// Far-side model of the inhibit and sync-on pins: pull-ups plus a pulse driver.
`timescale 1ns/1ps
module pin_partner (
  input  wire logic ref_clk,
  input  wire logic inhibitOut,
  input  wire logic inhibitOe,
  input  wire logic syncOut,
  input  wire logic syncOe,
  output wire logic inhibitIn,
  output wire logic syncIn
);
  logic inhDrv = 1'b0;
  logic syncDrv = 1'b0;

  // Pull-ups give a released pin a firm high instead of a floating value.
  assign inhibitIn = inhibitOe ? inhibitOut : ~inhDrv;
  assign syncIn = syncOe ? syncOut : ~syncDrv;

  task level_inhibit_status(input logic v);
    inhDrv <= v;
  endtask

  // Holds one pin low for n whole cycles; only the pulsed pin is released afterwards.
  task pulse(input logic sel, input int n);
    begin
      if (sel) syncDrv <= 1'b1;
      else inhDrv <= 1'b1;
      repeat (n) @(posedge ref_clk);
      if (sel) syncDrv <= 1'b0;
      else inhDrv <= 1'b0;
    end
  endtask
endmodule // pin_partner

// ==== verif/inhibit_sync_io_control_monitor.sv ====
// Checker for the state and pin ports of the inhibit and sync-on block.
`timescale 1ns/1ps
module inhibit_sync_io_control_monitor #(
  parameter MIN_LOW_CYCLES = 7500
) (
  input wire ref_clk,
  input wire resetn,
  input wire inhibitIn,
  input wire syncOut,
  input wire syncOe,
  input wire outputOn,
  input wire outputActive,
  input wire levelInhibitStatus,
  input wire tripProtectionStatus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  reg [15:0] emitCnt;
  reg [15:0] inhCnt;
  reg        emitting;
  reg        lastInh;
  reg        lastOe;
  reg        lastOn;

  // The stable count saturates so a long idle pin cannot wrap into a short one.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      emitCnt  <= 16'h0;
      inhCnt   <= 16'h0;
      emitting <= 1'b0;
      lastInh  <= 1'b1;
      lastOe   <= 1'b0;
      lastOn   <= 1'b0;
    end else begin
      emitCnt  <= syncOe ? emitCnt + 16'h1 : 16'h0;
      inhCnt   <= (inhibitIn != lastInh) ? 16'h0 : inhCnt + {15'h0, inhCnt != 16'hffff};
      lastInh  <= inhibitIn;
      lastOe   <= syncOe;
      lastOn   <= outputOn;
      emitting <= (syncOe && !lastOe && outputOn && !lastOn) || (emitting && syncOe);
    end
  end

  property p_active_on; outputActive |-> outputOn; endproperty
  a_active_on: assert property (p_active_on) else $error("active output while off");
  property p_level_flag; levelInhibitStatus |-> outputOn && !outputActive; endproperty
  a_level_flag: assert property (p_level_flag) else $error("level flag mismatch");
  property p_level_end; $fell(levelInhibitStatus) && outputOn |-> outputActive; endproperty
  a_level_end: assert property (p_level_end) else $error("output not restored");
  property p_emit_start; $rose(outputOn) |-> syncOe; endproperty
  a_emit_start: assert property (p_emit_start) else $error("no sync pulse on turn on");
  property p_emit_width; $fell(syncOe) && emitting |-> emitCnt >= MIN_LOW_CYCLES; endproperty
  a_emit_width: assert property (p_emit_width) else $error("sync pulse too short");
  property p_emit_level; emitting && syncOe |-> $stable(syncOut); endproperty
  a_emit_level: assert property (p_emit_level) else $error("sync pulse level moved");
  property p_trip_lock; $rose(outputOn) |-> !tripProtectionStatus; endproperty
  a_trip_lock: assert property (p_trip_lock) else $error("turned on while tripped");
  property p_trip_off; $rose(tripProtectionStatus) |-> !outputOn; endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip left output on");
  property p_trip_width; $rose(tripProtectionStatus) |-> inhCnt >= MIN_LOW_CYCLES; endproperty
  a_trip_width: assert property (p_trip_width) else $error("trip on short pulse");
endmodule // inhibit_sync_io_control_monitor

bind inhibit_sync_io_control inhibit_sync_io_control_monitor #(
  .MIN_LOW_CYCLES(MIN_LOW_CYCLES)
) u_mon (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .inhibitIn(inhibitIn),
  .syncOut(syncOut),
  .syncOe(syncOe),
  .outputOn(outputOn),
  .outputActive(outputActive),
  .levelInhibitStatus(levelInhibitStatus),
  .tripProtectionStatus(tripProtectionStatus)
);

// ==== verif/testbench.sv ====
// Self-checking bench for the inhibit and sync-on block with a small state model.
`timescale 1ns/1ps
module testbench;
  localparam MIN = 8;
  logic ref_clk, resetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hreadyout, hresp, inhibitIn, inhibitOut, inhibitOe, syncIn, syncOut, syncOe;
  wire outputOn, outputActive, levelInhibitStatus, tripProtectionStatus, irq;
  int fails, samples_checked, c, n, mOn, mAct, mLvl, mTrip, mIrq;

  inhibit_sync_io_control #(.MIN_LOW_CYCLES(MIN)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .inhibitIn(inhibitIn), .inhibitOut(inhibitOut), .inhibitOe(inhibitOe),
    .syncIn(syncIn), .syncOut(syncOut), .syncOe(syncOe), .outputOn(outputOn),
    .outputActive(outputActive), .levelInhibitStatus(levelInhibitStatus),
    .tripProtectionStatus(tripProtectionStatus), .irq(irq));
  pin_partner P (.ref_clk(ref_clk), .inhibitOut(inhibitOut), .inhibitOe(inhibitOe),
    .syncOut(syncOut), .syncOe(syncOe), .inhibitIn(inhibitIn), .syncIn(syncIn));

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task close_out;
    begin
      $display("compared %0d mismatched %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      samples_checked++;
      if (seen !== exp) begin
        fails++;
        $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Bounded so a slave that never answers ends the run instead of hanging it.
  task wait_ready;
    int k;
    begin
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
        fails++;
        close_out;
      end
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    begin
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_ready;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
      q = hrdata;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task chk_state;
    logic [31:0] q;
    begin
      bus(1'b0, 8'h08, 32'h0, q);
      check(q & 32'hf, mOn + 2 * mAct + 4 * mLvl + 8 * mTrip);
      // The response bit rides along at bit 4 and must stay OKAY.
      check({hresp, tripProtectionStatus, levelInhibitStatus, outputActive, outputOn},
            mOn + 2 * mAct + 4 * mLvl + 8 * mTrip);
      check({31'h0, irq}, mIrq);
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    {resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {fails, samples_checked, mOn, mAct, mLvl, mTrip, mIrq} = '0;
    seed = 32'hbd3d;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge ref_clk);
    for (c = 0; c < 8; c++) begin
      bus(1'b0, 8'(c * 4), 32'h0, r);
      check(r, (c == 2) ? 32'h60 : 32'h0);
    end
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h18, seed);
      bus(1'b0, 8'h18, 32'h0, r);
      check(r, seed);
    end
    wr(8'h14, 32'h0002_0004);
    for (c = 0; c < 6; c++) begin
      wr(8'h00, 32'h2 | ((c >> 1) << 2) | (c & 1));
      repeat (4) @(posedge ref_clk);
      n = 0;
      repeat (40) begin
        @(posedge ref_clk);
        n += (inhibitOut === 1'(c & 1));
      end
      check(n, ((c >> 1) == 1) ? 40 : ((c >> 1) == 2) ? 20 : 0);
      check({31'h0, inhibitOe}, 1);
    end
    wr(8'h00, 32'h0);
    // Lets the released inhibit pin settle through the synchroniser before turn-on.
    repeat (4) @(posedge ref_clk);
    wr(8'h04, 32'h1);
    {mOn, mAct} = {32'd1, 32'd1};
    repeat (3) @(posedge ref_clk);
    check({syncOe, syncOut}, 2'b10);
    chk_state;
    repeat (12) @(posedge ref_clk);
    check({31'h0, syncOe}, 0);
    P.level_inhibit_status(1'b1);
    repeat (6) @(posedge ref_clk);
    {mAct, mLvl} = {32'd0, 32'd1};
    chk_state;
    P.level_inhibit_status(1'b0);
    repeat (6) @(posedge ref_clk);
    {mAct, mLvl} = {32'd1, 32'd0};
    chk_state;
    wr(8'h10, 32'h7);
    mIrq = 1;
    chk_state;
    wr(8'h0c, 32'h4);
    mIrq = 0;
    chk_state;
    wr(8'h00, 32'h1);
    repeat (6) @(posedge ref_clk);
    {mAct, mLvl, mIrq} = {32'd0, 32'd1, 32'd1};
    chk_state;
    wr(8'h00, 32'h10);
    repeat (6) @(posedge ref_clk);
    wr(8'h0c, 32'h4);
    {mAct, mLvl, mIrq} = {32'd1, 32'd0, 32'd0};
    chk_state;
    P.pulse(1'b0, MIN - 3);
    repeat (MIN + 6) @(posedge ref_clk);
    chk_state;
    P.pulse(1'b0, MIN + 4);
    repeat (6) @(posedge ref_clk);
    {mOn, mAct, mTrip, mIrq} = {32'd0, 32'd0, 32'd1, 32'd1};
    chk_state;
    wr(8'h04, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk_state;
    wr(8'h04, 32'h4);
    wr(8'h0c, 32'h1);
    {mTrip, mIrq} = {32'd0, 32'd0};
    chk_state;
    wr(8'h04, 32'h1);
    {mOn, mAct} = {32'd1, 32'd1};
    repeat (3) @(posedge ref_clk);
    chk_state;
    repeat (12) @(posedge ref_clk);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h2);
    {mOn, mAct} = {32'd0, 32'd0};
    P.pulse(1'b1, MIN + 4);
    repeat (6) @(posedge ref_clk);
    {mOn, mAct, mIrq} = {32'd1, 32'd1, 32'd1};
    chk_state;
    repeat (12) @(posedge ref_clk);
    P.pulse(1'b1, MIN + 4);
    repeat (6) @(posedge ref_clk);
    chk_state;
    bus(1'b0, 8'h0c, 32'h0, r);
    check(r, 32'h2);
    // Sync pin in static output, value 1, first inverted and then not.
    wr(8'h00, 32'h700);
    repeat (4) @(posedge ref_clk);
    check({syncOe, syncOut}, 2'b11);
    wr(8'h00, 32'h600);
    repeat (4) @(posedge ref_clk);
    check({syncOe, syncOut}, 2'b10);
    close_out;
  end
endmodule // testbench
